// ===== rmt_pkg.sv
// Purpose: constants for the run-mode and trigger controller
// Assumes: 10 MHz REF_CLK, 32-bit APB register bus
// Notes: delay time is held as a count of 20 ns ticks
package rmt_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SRC = 8'h04;
	localparam logic [7:0] ADDR_BURST = 8'h08;
	localparam logic [7:0] ADDR_DCYC = 8'h0C;
	localparam logic [7:0] ADDR_DTIME = 8'h10;
	localparam logic [7:0] ADDR_SWTRIG = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// ==========================================================
	// control fields
	localparam int CTRL_CONT = 0;
	localparam int CTRL_BURST = 1;
	localparam int CTRL_GATE = 2;
	localparam int CTRL_TRANS = 3;
	localparam int CTRL_NEG = 4;
	localparam int CTRL_DLY = 5;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RST = 6'h01;
	localparam int SRC_LINE_LSB = 4;
	localparam int SRC_LINE_W = 3;
	localparam int SRC_W = 2;
	localparam logic [1:0] SRC_EXT = 2'h0;
	localparam logic [1:0] SRC_BP = 2'h1;
	localparam logic [1:0] SRC_BUS = 2'h2;
	// ==========================================================
	// ranges and timing
	localparam int CNT_W = 21;
	localparam int TICK_W = 30;
	localparam logic [20:0] BURST_MIN = 21'h000001;
	localparam logic [20:0] BURST_MAX = 21'h0F4240;
	localparam logic [20:0] BURST_RST = 21'h000001;
	localparam logic [20:0] DCYC_MIN = 21'h00000A;
	localparam logic [20:0] DCYC_MAX = 21'h1E8480;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_NS = 20;
	localparam int DLY_TIME_MIN_NS = 100;
	localparam logic [29:0] TICKS_PER_CLK =
		30'(CLK_PERIOD_NS / TICK_NS);
	localparam logic [29:0] DTIME_MIN =
		30'(DLY_TIME_MIN_NS / TICK_NS);
	localparam logic [29:0] DTIME_MAX = 30'h3B9ACA00;
	localparam logic [29:0] DTIME_RST = DTIME_MIN;
	// ==========================================================
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DELAY = 2'b01,
		ST_RUN = 2'b10
	} rmt_state_t;
endpackage

// ===== rmt_dly_if.sv
// Purpose: link between controller and trigger delay counter
// Assumes: one clock domain
// Notes: start and done are one-cycle pulses
`timescale 1ns/100ps
interface rmt_dly_if;
	logic start;
	logic use_cycles;
	logic [20:0] cycles;
	logic [29:0] ticks;
	logic sample_tick;
	logic busy;
	logic done;
	modport ctl (output start, output use_cycles, output cycles,
		output ticks, output sample_tick, input busy, input done);
	modport dly (input start, input use_cycles, input cycles,
		input ticks, input sample_tick, output busy, output done);
endinterface

// ===== rmt_delay.sv
// Purpose: trigger delay counter, sample cycles or 20 ns ticks
// Assumes: sample_tick marks one sample clock period
// Notes: time delay rounds up to whole REF_CLK periods
`timescale 1ns/100ps
module rmt_delay
	import rmt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	rmt_dly_if.dly d
);
	logic [29:0] cnt_q;
	logic [29:0] cnt_d;
	logic busy_q;
	logic busy_d;
	logic done_q;
	logic done_d;
	logic mode_q;
	logic mode_d;

	// ==========================================================
	// countdown
	wire cyc_last = mode_q & d.sample_tick &
		(cnt_q == 30'h00000001);
	wire tick_last = ~mode_q & (cnt_q <= TICKS_PER_CLK);
	wire last = busy_q & (cyc_last | tick_last);

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		mode_d = mode_q;
		done_d = 1'b0;
		if (d.start) begin
			mode_d = d.use_cycles;
			cnt_d = d.use_cycles ? {9'h000, d.cycles} : d.ticks;
			busy_d = 1'b1;
		end else if (last) begin
			busy_d = 1'b0;
			done_d = 1'b1;
			cnt_d = 30'h00000000;
		end else if (busy_q & mode_q & d.sample_tick) begin
			cnt_d = cnt_q - 30'h00000001;
		end else if (busy_q & ~mode_q) begin
			cnt_d = cnt_q - TICKS_PER_CLK;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 30'h00000000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			mode_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
			mode_q <= mode_d;
		end
	end

	assign d.busy = busy_q;
	assign d.done = done_q;
endmodule

// ===== rmt_ctrl.sv
// Purpose: run mode, trigger, burst, delay and gate control
// Assumes: all inputs synchronous to REF_CLK, APB slave
// Notes: drives RUN_ENABLE and WAVE_START to the playback engine
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/100ps
// Overview of operation
// - run continuously when the mode bit is 1, interrupted when 0
// - trigger, burst, delay, gate settings act only in interrupted mode
// - interrupted mode offers triggered, gated or counted burst
// - software trigger works only interrupted with bus source
// - burst enable bit turns burst on or off, resets to 0
// - burst outputs programmed cycles per trigger, 1 to 1M, default 1
// - cycle delay accepts 0 or 10 to 2e6 sample clocks
// - delay enable bit switches time delay on or off, default 0
// - time delay 100 ns to 20 s in 20 ns steps, default 100 ns
// - with delay active, wait the delay after trigger then start
// - gate style level or transition; polarity applies to both
// - transition gating opens on one edge, closes on next
// - polarity picks open level and which edge direction counts
// - gate enable bit turns gated mode on or off, default 0
// - gating comes from front input or a backplane line
// - bus source ignores front input and backplane lines
// - every setting reads back its programmed value
module rmt_ctrl
	import rmt_pkg::*;
#(
	parameter int LINES = 8
)
(
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TRIG_IN,
	input wire logic [LINES-1:0] BP_TRIG,
	input wire logic SAMPLE_TICK,
	input wire logic WAVE_END,
	output logic RUN_ENABLE,
	output logic WAVE_START
);
	// ==========================================================
	// decoding helpers
	function automatic logic active_lvl(input logic s, input logic n);
		active_lvl = s ^ n;
	endfunction

	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] b);
		hit = (a == b);
	endfunction

	function automatic logic in_span(input logic [CNT_W-1:0] v,
		input logic [CNT_W-1:0] lo, input logic [CNT_W-1:0] hi);
		in_span = (v >= lo) & (v <= hi);
	endfunction

	// ==========================================================
	// registers
	logic [CTRL_W-1:0] ctrl_q;
	logic [SRC_W-1:0] src_q;
	logic [SRC_LINE_W-1:0] line_q;
	logic [CNT_W-1:0] burst_q;
	logic [CNT_W-1:0] dcyc_q;
	logic [TICK_W-1:0] dtime_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	rmt_state_t state_q;
	rmt_state_t state_d;
	logic [CNT_W-1:0] remain_q;
	logic [CNT_W-1:0] remain_d;
	logic gate_q;
	logic gate_d;
	logic prev_q;
	logic src_chg_q;
	logic gate_open;
	logic run_q;
	logic run_d;
	logic start_q;
	logic start_d;

	rmt_dly_if dif();

	// ==========================================================
	// APB decode
	wire setup = PSEL & ~PENABLE;
	wire wr = PSEL & PENABLE & PWRITE & pready_q;
	wire is_ctrl = hit(PADDR, ADDR_CTRL);
	wire is_src = hit(PADDR, ADDR_SRC);
	wire is_burst = hit(PADDR, ADDR_BURST);
	wire is_dcyc = hit(PADDR, ADDR_DCYC);
	wire is_dtime = hit(PADDR, ADDR_DTIME);
	wire is_sw = hit(PADDR, ADDR_SWTRIG);
	wire is_stat = hit(PADDR, ADDR_STATUS);
	wire mapped = is_ctrl | is_src | is_burst | is_dcyc | is_dtime |
		is_sw | is_stat;
	wire [CNT_W-1:0] wd_cnt = PWDATA[CNT_W-1:0];
	wire [TICK_W-1:0] wd_tick = PWDATA[TICK_W-1:0];
	wire src_wr = wr & is_src;
	wire src_ok = (PWDATA[SRC_W-1:0] != 2'h3);
	wire burst_ok = (PWDATA[31:CNT_W] == 11'h000) &
		in_span(wd_cnt, BURST_MIN, BURST_MAX);
	wire dcyc_ok = (PWDATA[31:CNT_W] == 11'h000) &
		((wd_cnt == 21'h000000) |
		in_span(wd_cnt, DCYC_MIN, DCYC_MAX));
	wire dtime_ok = (PWDATA[31:TICK_W] == 2'h0) &
		(wd_tick >= DTIME_MIN) & (wd_tick <= DTIME_MAX);

	// ==========================================================
	// read mux
	always_comb begin
		prdata_d = 32'h00000000;
		if (is_ctrl) begin
			prdata_d[CTRL_W-1:0] = ctrl_q;
		end else if (is_src) begin
			prdata_d[SRC_W-1:0] = src_q;
			prdata_d[SRC_LINE_LSB +: SRC_LINE_W] = line_q;
		end else if (is_burst) begin
			prdata_d[CNT_W-1:0] = burst_q;
		end else if (is_dcyc) begin
			prdata_d[CNT_W-1:0] = dcyc_q;
		end else if (is_dtime) begin
			prdata_d[TICK_W-1:0] = dtime_q;
		end else if (is_stat) begin
			prdata_d[1:0] = state_q;
			prdata_d[2] = run_q;
			prdata_d[3] = gate_open;
		end
	end

	// ==========================================================
	// mode and trigger decode
	wire cont = ctrl_q[CTRL_CONT];
	wire intr = ~cont;
	wire neg = ctrl_q[CTRL_NEG];
	wire bus_src = (src_q == SRC_BUS);
	wire sel_sig = (src_q == SRC_BP) ? BP_TRIG[line_q] : TRIG_IN;
	wire act = active_lvl(sel_sig, neg);
	wire prev_act = active_lvl(prev_q, neg);
	wire edge_q = act & ~prev_act & ~bus_src & ~src_chg_q;
	wire sw_trig = wr & is_sw & PWDATA[0] & bus_src;
	wire gated = intr & ctrl_q[CTRL_GATE];
	wire trig = intr & ~ctrl_q[CTRL_GATE] & (edge_q | sw_trig);
	assign gate_open = ~bus_src &
		(ctrl_q[CTRL_TRANS] ? gate_q : act);
	wire use_cyc = (dcyc_q != 21'h000000);
	wire dly_on = use_cyc | ctrl_q[CTRL_DLY];
	wire [CNT_W-1:0] count_eff =
		ctrl_q[CTRL_BURST] ? burst_q : BURST_MIN;

	// ==========================================================
	// transition gate toggle
	always_comb begin
		gate_d = gate_q;
		if (~gated | ~ctrl_q[CTRL_TRANS]) begin
			gate_d = 1'b0;
		end else if (edge_q) begin
			gate_d = ~gate_q;
		end
	end

	// ==========================================================
	// trigger sequencer
	always_comb begin
		state_d = state_q;
		remain_d = remain_q;
		start_d = 1'b0;
		dif.start = 1'b0;
		case (state_q)
		ST_IDLE: begin
			if (trig & dly_on) begin
				state_d = ST_DELAY;
				dif.start = 1'b1;
			end else if (trig) begin
				state_d = ST_RUN;
				start_d = 1'b1;
			end
			remain_d = count_eff;
		end
		ST_DELAY: begin
			if (dif.done) begin
				state_d = ST_RUN;
				start_d = 1'b1;
			end
		end
		ST_RUN: begin
			if (WAVE_END & (remain_q <= BURST_MIN)) begin
				state_d = ST_IDLE;
			end else if (WAVE_END) begin
				remain_d = remain_q - BURST_MIN;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
		if (~intr | gated) begin
			state_d = ST_IDLE;
			start_d = 1'b0;
			dif.start = 1'b0;
		end
	end

	always_comb begin
		if (cont) begin
			run_d = 1'b1;
		end else if (gated) begin
			run_d = gate_open;
		end else begin
			run_d = (state_d == ST_RUN);
		end
	end

	assign dif.use_cycles = use_cyc;
	assign dif.cycles = dcyc_q;
	assign dif.ticks = dtime_q;
	assign dif.sample_tick = SAMPLE_TICK;

	rmt_delay u_delay (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.d(dif)
	);

	// ==========================================================
	// register writes
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_q <= CTRL_RST;
			src_q <= SRC_EXT;
			line_q <= '0;
			burst_q <= BURST_RST;
			dcyc_q <= 21'h000000;
			dtime_q <= DTIME_RST;
		end else if (wr) begin
			if (is_ctrl) begin
				ctrl_q <= PWDATA[CTRL_W-1:0];
			end
			if (src_wr & src_ok) begin
				src_q <= PWDATA[SRC_W-1:0];
				line_q <= PWDATA[SRC_LINE_LSB +: SRC_LINE_W];
			end
			if (is_burst & burst_ok) begin
				burst_q <= wd_cnt;
			end
			if (is_dcyc & dcyc_ok) begin
				dcyc_q <= wd_cnt;
			end
			if (is_dtime & dtime_ok) begin
				dtime_q <= wd_tick;
			end
		end
	end

	// ==========================================================
	// bus answer and engine outputs
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			prdata_q <= setup ? prdata_d : 32'h00000000;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= ST_IDLE;
			remain_q <= BURST_RST;
			gate_q <= 1'b0;
			prev_q <= 1'b0;
			src_chg_q <= 1'b0;
			run_q <= 1'b1;
			start_q <= 1'b0;
		end else begin
			state_q <= state_d;
			remain_q <= remain_d;
			gate_q <= gate_d;
			prev_q <= sel_sig;
			src_chg_q <= src_wr;
			run_q <= run_d;
			start_q <= start_d;
		end
	end

	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign PRDATA = prdata_q;
	assign RUN_ENABLE = run_q;
	assign WAVE_START = start_q;
endmodule

// ===== rmt_ctrl_asserts.sv
// Purpose: port checks for the run-mode controller
// Assumes: one clock domain, async active-low reset
// Notes: bound to every rmt_ctrl instance
`timescale 1ns/100ps
module rmt_ctrl_chk (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic RUN_ENABLE,
	input wire logic WAVE_START
);
	// ========================================
	// bus and start checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	sequence setup_s;
		PSEL && !PENABLE;
	endsequence
	sequence access_s;
		PSEL && PENABLE && PREADY;
	endsequence
	bus_ready_a: assert property (setup_s |=> access_s)
		else $error("no ready after setup");
	ready_cause_a: assert property (PREADY |-> $past(PSEL && !PENABLE))
		else $error("ready without setup");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready too long");
	err_access_a: assert property (PSLVERR |-> access_s)
		else $error("error outside access");
	rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data outside access");
	start_pulse_a: assert property (WAVE_START |=> !WAVE_START)
		else $error("start too long");
	start_run_a: assert property (WAVE_START |-> RUN_ENABLE)
		else $error("start without run");
	start_idle_a: assert property (WAVE_START |-> !$past(RUN_ENABLE))
		else $error("start while running");
endmodule
bind rmt_ctrl rmt_ctrl_chk rmt_ctrl_chk_inst (.REF_CLK(REF_CLK),
	.RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .RUN_ENABLE(RUN_ENABLE),
	.WAVE_START(WAVE_START));

// ===== rmt_engine_model.sv
// Purpose: playback engine and sample clock stand-in
// Assumes: waveform of four clocks, sample tick every other clock
// Notes: sample clock runs free
`timescale 1ns/100ps
module rmt_engine_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic start,
	output logic wave_end,
	output logic sample_tick
);
	// ========================================
	// waveform pacing
	logic [1:0] cnt_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 2'h0;
			wave_end <= 1'b0;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= !sample_tick;
			cnt_q <= (start || wave_end) ? 2'h0 : cnt_q + 2'h1;
			wave_end <= run && !start && cnt_q == 2'h2;
		end
	end
endmodule

// ===== tb_rmt_ctrl.sv
// Purpose: self-checking bench for the run-mode controller
// Assumes: APB answers after one access cycle
// Notes: engine model closes waveforms and paces ticks
`timescale 1ns/100ps
module tb_rmt_ctrl;
	import rmt_pkg::*;
	// ========================================
	// bench state
	logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, trig = 0;
	logic [7:0] paddr = 8'h00, bp = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, run, wstart, wend, stick, er;
	int failures = 0, n_checks = 0, ends = 0, c = 0;
	logic [7:0] ra [6] = '{ADDR_CTRL, ADDR_SRC, ADDR_BURST, ADDR_DCYC,
		ADDR_DTIME, ADDR_STATUS};
	logic [31:0] rv [6] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h5, 32'h4};
	always #50 clk = ~clk;
	rmt_ctrl rmt_ctrl_inst (.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TRIG_IN(trig),
		.BP_TRIG(bp), .SAMPLE_TICK(stick), .WAVE_END(wend),
		.RUN_ENABLE(run), .WAVE_START(wstart));
	rmt_engine_model rmt_engine_model_inst (.clk(clk), .rst_b(rst_b),
		.run(run), .start(wstart), .wave_end(wend), .sample_tick(stick));
	always @(posedge clk) if (run === 1'b1 && wend === 1'b1) ends++;
	// ========================================
	// tasks
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wrd(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		apb(1'b1, a, d);
		apb(1'b0, a, 32'h0);
		cmp(rd, e);
	endtask
	task automatic waitst();
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (wstart !== 1'b1 && c < 60);
	endtask
	task automatic pulse();
		@(posedge clk);
		ends = 0;
		trig <= 1'b1;
		waitst();
		trig <= 1'b0;
	endtask
	task automatic wfall();
		c = 0;
		while (run === 1'b1 && c < 100) begin
			@(posedge clk);
			c++;
		end
	endtask
	task automatic gchk(input logic t, input logic [7:0] b, input logic e);
		trig <= t;
		bp <= b;
		repeat (3) @(posedge clk);
		cmp({31'h0, run}, {31'h0, e});
	endtask
	task automatic rng(input int lo, input int hi);
		cmp({31'h0, c >= lo && c <= hi}, 32'h1);
	endtask
	task automatic conclude();
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ========================================
	// watchdog and tests
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		conclude();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		foreach (ra[i]) begin
			apb(1'b0, ra[i], 32'h0);
			cmp(rd, rv[i]);
			cmp({31'h0, er}, 32'h0);
		end
		apb(1'b0, 8'h40, 32'h0);
		cmp({31'h0, er}, 32'h1);
		pulse();
		cmp(c, 60);
		cmp({31'h0, run}, 32'h1);
		apb(1'b1, ADDR_CTRL, 32'h5);
		gchk(1'b0, 8'h00, 1'b1);
		wrd(ADDR_BURST, 32'h0, 32'h1);
		wrd(ADDR_DCYC, 32'h5, 32'h0);
		wrd(ADDR_DTIME, 32'h4, 32'h5);
		wrd(ADDR_CTRL, 32'h3E, 32'h3E);
		wrd(ADDR_BURST, 32'h3, 32'h3);
		wrd(ADDR_SRC, 32'h31, 32'h31);
		wrd(ADDR_SRC, 32'h3, 32'h31);
		apb(1'b1, ADDR_CTRL, 32'h2);
		apb(1'b1, ADDR_SRC, 32'h0);
		pulse();
		cmp(c, 2);
		wfall();
		cmp(ends, 3);
		apb(1'b1, ADDR_SRC, 32'h2);
		pulse();
		cmp(c, 60);
		apb(1'b1, ADDR_SWTRIG, 32'h1);
		waitst();
		rng(1, 3);
		wfall();
		apb(1'b1, ADDR_SRC, 32'h0);
		apb(1'b1, ADDR_SWTRIG, 32'h1);
		waitst();
		cmp(c, 60);
		apb(1'b1, ADDR_DCYC, 32'hA);
		pulse();
		rng(20, 26);
		wfall();
		apb(1'b1, ADDR_DCYC, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h22);
		apb(1'b1, ADDR_DTIME, 32'h32);
		pulse();
		rng(12, 16);
		wfall();
		apb(1'b1, ADDR_CTRL, 32'h0);
		pulse();
		wfall();
		cmp(ends, 1);
		apb(1'b1, ADDR_CTRL, 32'h4);
		gchk(1'b1, 8'h00, 1'b1);
		gchk(1'b0, 8'h00, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h14);
		gchk(1'b1, 8'h00, 1'b0);
		gchk(1'b0, 8'h00, 1'b1);
		apb(1'b1, ADDR_CTRL, 32'hC);
		gchk(1'b1, 8'h00, 1'b1);
		gchk(1'b0, 8'h00, 1'b1);
		gchk(1'b1, 8'h00, 1'b0);
		gchk(1'b0, 8'h00, 1'b0);
		apb(1'b1, ADDR_SRC, 32'h31);
		apb(1'b1, ADDR_CTRL, 32'h4);
		gchk(1'b0, 8'h08, 1'b1);
		gchk(1'b0, 8'h00, 1'b0);
		apb(1'b1, ADDR_SRC, 32'h2);
		gchk(1'b1, 8'h08, 1'b0);
		conclude();
	end
endmodule
